// *** sim/mpi_servo_model.sv ***
// servo drive stand-in: logs peak speed and step counts of each axis reference
`timescale 1ns/100ps
module mpi_servo_model (
  // clock and clear
  input wire logic clk_in,
  input wire logic clear_in,
  // references from the interpolator
  input wire logic [63:0] speed_ref_in,
  // logged profile, 16 bits per axis
  output logic [63:0] peak_out,
  output logic [63:0] rise_out,
  output logic [63:0] fall_out
);
  for (genvar g = 0; g < 4; g++) begin : g_axis
    logic [15:0] last_reg;
    logic [15:0] pk_reg;
    logic [15:0] up_reg;
    logic [15:0] dn_reg;
    wire logic [15:0] v = speed_ref_in[g*16+:16];
    // a step up is one accel period, a step down one decel period
    always_ff @(posedge clk_in) begin
      if (clear_in) begin
        last_reg <= 16'h0000;
        pk_reg <= 16'h0000;
        up_reg <= 16'h0000;
        dn_reg <= 16'h0000;
      end else begin
        last_reg <= v;
        if (v > pk_reg) pk_reg <= v;
        if (v > last_reg) up_reg <= up_reg + 16'h0001;
        if (v < last_reg) dn_reg <= dn_reg + 16'h0001;
      end
    end
    assign peak_out[g*16+:16] = pk_reg;
    assign rise_out[g*16+:16] = up_reg;
    assign fall_out[g*16+:16] = dn_reg;
  end
endmodule : mpi_servo_model

// *** sim/mpi_top_properties.sv ***
// concurrent checks on the interpolator top-level ports
`timescale 1ns/100ps
module mpi_top_properties #(
  parameter int AXES = 4,
  parameter int CTRL_CYC = 250
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // move request and limit
  input wire logic move_valid_in,
  input wire mpi_pkg::mpi_move_t move_in,
  input wire logic [mpi_pkg::VW-1:0] interp_max_feed_in,
  // outputs under watch
  input wire logic move_ready_out,
  input wire logic [AXES*mpi_pkg::VW-1:0] speed_ref_out,
  input wire logic move_done_out,
  input wire logic supplemental_axis_overspeed_error_out
);
  logic [15:0] since_reg;
  logic seen_reg;
  wire logic err_w = supplemental_axis_overspeed_error_out;
  wire logic over_w = (move_in.kind == mpi_pkg::MPI_HELIX) &&
    (48'(move_in.sup_len) * 48'(move_in.feed) > 48'(interp_max_feed_in) * 48'(move_in.path_len));
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // cycles since the references last moved, saturating
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      since_reg <= 16'h0000;
      seen_reg <= 1'b0;
    end else if ($changed(speed_ref_out)) begin
      since_reg <= 16'h0000;
      seen_reg <= 1'b1;
    end else if (since_reg != 16'hffff) begin
      since_reg <= since_reg + 16'h0001;
    end
  end
  sequence s_take;
    move_valid_in && move_ready_out;
  endsequence
  sequence s_over_take;
    s_take ##0 over_w;
  endsequence
  a_over_raises: assert property (s_over_take |-> ##[1:600] err_w)
    else $error("helix overspeed not flagged");
  a_err_sticky: assert property (err_w |=> err_w)
    else $error("overspeed error dropped without reset");
  a_err_halts: assert property (err_w |-> speed_ref_out == '0 && !move_ready_out)
    else $error("motion continues under overspeed error");
  a_ref_period: assert property ($changed(speed_ref_out) && seen_reg && !err_w |->
    since_reg >= 16'(CTRL_CYC - 1)) else $error("speed reference stepped off the period");
  a_idle_still: assert property (move_ready_out |-> speed_ref_out == '0)
    else $error("speed reference not zero while idle");
  a_take_busy: assert property (s_take |=> !move_ready_out)
    else $error("ready still high after a move was taken");
  a_done_single: assert property (move_done_out |-> move_ready_out ##1 !move_done_out)
    else $error("done pulse not single or ready not back with it");
  a_ready_returns: assert property (move_done_out |-> ##[1:3] move_ready_out)
    else $error("ready did not return after done");
  a_reset_clears: assert property (disable iff (1'b0) !rst_b_in |=>
    speed_ref_out == '0 && !move_done_out && !move_ready_out && !err_w)
    else $error("outputs not cleared by reset");
endmodule : mpi_top_properties
bind mpi_top mpi_top_properties #(.AXES(AXES), .CTRL_CYC(CTRL_CYC)) i_mpi_top_properties (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .move_valid_in(move_valid_in), .move_in(move_in),
  .interp_max_feed_in(interp_max_feed_in), .move_ready_out(move_ready_out),
  .speed_ref_out(speed_ref_out), .move_done_out(move_done_out),
  .supplemental_axis_overspeed_error_out(supplemental_axis_overspeed_error_out));

// *** sim/mpi_top_test.sv ***
// self-checking bench for the motion profile interpolator
`timescale 1ns/100ps
module mpi_top_test;
  typedef struct {
    int k, s, d0, d1, pl, f, su, ce, pm, ov, ld, pk, ac, dc;
  } mpi_row_t;
  mpi_row_t rows [11];
  mpi_row_t hand;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce, pm, chg, mv, clr, rdy, done, err;
  logic [7:0] ov;
  mpi_pkg::mpi_ramp_t chg_r;
  mpi_pkg::mpi_move_t mo;
  logic [63:0] sref, pk, up, dn;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // 250 MHz clock
  always #2 clk_in = ~clk_in;
  // max feed 100 per axis, ptp ramps 8/8, interpolation ramps 8/4, max rate 200
  mpi_top #(.CTRL_CYC(4)) i_mpi_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .axis_max_feed_in({4{16'h0064}}), .ptp_ramp_in(32'h0008_0008),
    .interp_ramp_in(32'h0008_0004), .interp_max_feed_in(16'h00c8),
    .const_accel_en_in(ce), .pass_mode_in(pm), .override_pct_in(ov),
    .parameter_change_command_in(chg), .parameter_change_ramp_in(chg_r),
    .move_valid_in(mv), .move_in(mo), .move_ready_out(rdy), .speed_ref_out(sref),
    .move_done_out(done), .supplemental_axis_overspeed_error_out(err));
  mpi_servo_model i_mpi_servo_model (.clk_in(clk_in), .clear_in(clr), .speed_ref_in(sref),
    .peak_out(pk), .rise_out(up), .fall_out(dn));
  task conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: value %0d, expected %0d", $time, got, want);
    end
  endtask : chk
  // one move: wait for ready, clear the log, hold valid across the taking edge
  task go(input mpi_row_t r, input bit wait_done);
    for (n = 0; n < 400 && rdy !== 1'b1; n++) @(negedge clk_in);
    ce = r.ce[0];
    pm = r.pm[0];
    ov = 8'(r.ov);
    mo.kind = mpi_pkg::mpi_kind_t'(r.k[1:0]);
    mo.axis_sel = 4'(r.s);
    mo.axis_dist = {24'h00_0000, 24'(r.su), 24'(r.d1), 24'(r.d0)};
    mo.path_len = 24'(r.pl);
    mo.feed = 16'(r.f);
    mo.sup_len = 24'(r.su);
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    mv = 1'b1;
    @(negedge clk_in);
    mv = 1'b0;
    for (n = 0; wait_done && n < 3000 && done !== 1'b1; n++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
  endtask : go
  task meas(input mpi_row_t r);
    if (r.pk != 0) chk(pk[r.ld*16+:16], 16'(r.pk));
    chk(up[r.ld*16+:16], 16'(r.ac));
    chk(dn[r.ld*16+:16], 16'(r.dc));
  endtask : meas
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    ce = 1'b0;
    pm = 1'b0;
    chg = 1'b0;
    mv = 1'b0;
    clr = 1'b0;
    ov = 8'h64;
    chg_r = 32'h0006_0003;
    mo = '0;
    rows = '{
      '{0, 1, 4000, 0, 4000, 100, 0, 0, 0, 100, 0, 100, 8, 8},
      '{0, 1, 4000, 0, 4000, 100, 0, 0, 0, 50, 0, 50, 4, 4},
      '{0, 1, 300, 0, 300, 100, 0, 0, 0, 100, 0, 0, 3, 3},
      '{1, 3, 3000, 4000, 5000, 100, 0, 0, 0, 100, 1, 80, 8, 4},
      '{1, 1, 2000, 0, 2000, 100, 0, 1, 0, 100, 0, 100, 4, 2},
      '{1, 3, 1200, 1600, 2000, 100, 0, 1, 0, 100, 1, 80, 8, 4},
      '{1, 1, 2000, 0, 2000, 50, 0, 0, 0, 100, 0, 50, 8, 4},
      '{2, 3, 1200, 1600, 2000, 100, 0, 0, 0, 100, 0, 60, 8, 4},
      '{3, 7, 1200, 1600, 2000, 100, 2000, 0, 0, 100, 2, 100, 8, 4},
      '{1, 1, 300, 0, 300, 100, 0, 0, 0, 100, 0, 0, 4, 2},
      '{1, 1, 300, 0, 300, 100, 0, 0, 1, 100, 0, 0, 8, 4}};
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    foreach (rows[i]) begin
      go(rows[i], 1'b1);
      meas(rows[i]);
    end
    // command-changed ramps replace the system ones
    chg = 1'b1;
    @(negedge clk_in);
    chg = 1'b0;
    hand = rows[6];
    hand.f = 100;
    hand.pk = 100;
    hand.ac = 6;
    hand.dc = 3;
    go(hand, 1'b1);
    meas(hand);
    // helix whose supplemental axis would need 300 against a limit of 200
    hand = rows[8];
    hand.su = 6000;
    go(hand, 1'b0);
    for (n = 0; n < 600 && err !== 1'b1; n++) @(negedge clk_in);
    repeat (8) @(negedge clk_in);
    chk(16'(err), 16'h0001);
    chk(16'(sref === 64'h0000_0000_0000_0000), 16'h0001);
    chk(16'(rdy), 16'h0000);
    // reset clears the error and restores the system ramps
    rst_b_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(16'(err), 16'h0000);
    rst_b_in = 1'b1;
    chk(16'(rdy), 16'h0000); // still the reset value before the first edge
    @(negedge clk_in);
    chk(16'(rdy), 16'h0001); // ready is back after the first edge past release
    @(negedge clk_in);
    chk(16'(rdy), 16'h0001);
    go(rows[6], 1'b1);
    meas(rows[6]);
    conclude();
  end
endmodule : mpi_top_test

// *** verilog/mpi_pkg.sv ***
// package of constants and carrier types for the motion profile interpolator
package mpi_pkg;
  localparam int AXES = 4;
  localparam int VW = 16;
  localparam int DW = 24;
  localparam int TW = 16;
  // control period, in ns, and its length in clock cycles at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [VW-1:0] SPEED_ZERO = 16'h0000;
  localparam logic [TW-1:0] TIME_ONE = 16'h0001;
  // move kinds
  typedef enum logic [1:0] {
    MPI_PTP = 2'h0,
    MPI_LINE = 2'h1,
    MPI_ARC = 2'h2,
    MPI_HELIX = 2'h3
  } mpi_kind_t;
  // ramp time pair, in control periods
  typedef struct packed {
    logic [TW-1:0] accel;
    logic [TW-1:0] decel;
  } mpi_ramp_t;
  // one move request
  typedef struct packed {
    mpi_kind_t kind;
    logic [AXES-1:0] axis_sel;
    logic [AXES*DW-1:0] axis_dist;
    logic [DW-1:0] path_len;
    logic [VW-1:0] feed;
    logic [DW-1:0] sup_len;
  } mpi_move_t;
endpackage : mpi_pkg

// *** verilog/mpi_ramp.sv ***
// trapezoid or triangle speed generator for one normalised profile
`timescale 1ns/100ps
module mpi_ramp #(
  parameter int VW = 16,
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic [VW-1:0] peak_in,
  input wire logic [TW-1:0] acc_t_in,
  input wire logic [TW-1:0] dec_t_in,
  input wire logic [TW-1:0] cruise_t_in,
  // profile
  output logic [VW-1:0] speed_out,
  output logic busy_out,
  output logic done_out
);
  initial begin
    if (VW < 4 || TW < 2) $error("mpi_ramp: widths too small");
  end
  typedef enum logic [3:0] {
    MPI_R_IDLE = 4'b0001,
    MPI_R_ACC = 4'b0010,
    MPI_R_RUN = 4'b0100,
    MPI_R_DEC = 4'b1000
  } mpi_rstate_t;
  mpi_rstate_t state_reg, state_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  logic [VW-1:0] speed_reg, speed_next;
  logic [VW-1:0] peak_reg;
  logic [TW-1:0] acc_reg, dec_reg, run_reg;
  logic done_reg;
  // speed at step k of a ramp of n steps is peak*k/n; fixed time, varying slope
  function automatic logic [VW-1:0] frac(input logic [VW-1:0] pk, input logic [TW-1:0] k,
                                         input logic [TW-1:0] n);
    logic [VW+TW-1:0] prod;
    prod = pk * k;
    frac = (n == '0) ? pk : VW'(prod / n);
  endfunction : frac
  wire logic [TW-1:0] cnt_inc = cnt_reg + TW'(1);
  // sequencing, stepped once per control period
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    speed_next = speed_reg;
    case (state_reg)
      MPI_R_IDLE: begin
        speed_next = '0;
        cnt_next = '0;
        if (start_in) state_next = MPI_R_ACC;
      end
      MPI_R_ACC: if (tick_in) begin
        speed_next = frac(peak_reg, cnt_inc, acc_reg);
        cnt_next = cnt_inc;
        if (cnt_inc >= acc_reg) begin
          cnt_next = '0;
          state_next = (run_reg == '0) ? MPI_R_DEC : MPI_R_RUN;
        end
      end
      MPI_R_RUN: if (tick_in) begin
        cnt_next = cnt_inc;
        if (cnt_inc >= run_reg) begin
          cnt_next = '0;
          state_next = MPI_R_DEC;
        end
      end
      MPI_R_DEC: if (tick_in) begin
        speed_next = frac(peak_reg, dec_reg - cnt_inc, dec_reg);
        cnt_next = cnt_inc;
        if (cnt_inc >= dec_reg) begin
          speed_next = '0;
          state_next = MPI_R_IDLE;
        end
      end
      default: state_next = MPI_R_IDLE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= MPI_R_IDLE;
      cnt_reg <= '0;
      speed_reg <= '0;
      peak_reg <= '0;
      acc_reg <= '0;
      dec_reg <= '0;
      run_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      speed_reg <= speed_next;
      done_reg <= (state_reg == MPI_R_DEC) && (state_next == MPI_R_IDLE);
      if (state_reg == MPI_R_IDLE && start_in) begin
        peak_reg <= peak_in;
        acc_reg <= (acc_t_in == '0) ? TW'(1) : acc_t_in;
        dec_reg <= (dec_t_in == '0) ? TW'(1) : dec_t_in;
        run_reg <= cruise_t_in;
      end
    end
  end
  assign speed_out = speed_reg;
  assign busy_out = (state_reg != MPI_R_IDLE);
  assign done_out = done_reg;
endmodule : mpi_ramp

// *** verilog/mpi_top.sv ***
// motion profile interpolator: per-axis speed references for ptp, line, arc and helix moves
// What this block does
// - ptp accel time is standstill to axis maximum feed rate
// - ptp decel time is axis maximum feed rate down to zero
// - ptp override keeps acceleration rate; peak speed and ramp durations scale together
// - short ptp move gives triangle with configured accel/decel ratio
// - line axis rate is axis distance over path length times command rate
// - interpolation ramp times are fixed on path speed; acceleration varies
// - constant-acceleration option is a plain input with no reset value here; full times while off
// - option on, one axis: ramp times scale by rate over max rate
// - two or more axes ignore the option and use full times
// - stop mode short move gives triangle keeping decel/accel ratio
// - pass mode keeps ramp times and lowers peak speed on short moves
// - arcs run as chains of short linear segments, same ramps
// - helix axis rate is command rate times axis length over arc length
// - helix axis rate above max interpolation rate raises overspeed error, stops
// - max rate from parameters; ramp times from parameters unless changed by command
// - ptp axes run independently with their own ramps and maximum rate
`timescale 1ns/100ps
module mpi_top #(
  parameter int AXES = mpi_pkg::AXES,
  parameter int CTRL_CYC = mpi_pkg::CTRL_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // system parameters
  input wire logic [AXES*mpi_pkg::VW-1:0] axis_max_feed_in,
  input wire mpi_pkg::mpi_ramp_t ptp_ramp_in,
  input wire mpi_pkg::mpi_ramp_t interp_ramp_in,
  input wire logic [mpi_pkg::VW-1:0] interp_max_feed_in,
  input wire logic const_accel_en_in,
  input wire logic pass_mode_in,
  input wire logic [7:0] override_pct_in,
  // parameter_change_command from the program
  input wire logic parameter_change_command_in,
  input wire mpi_pkg::mpi_ramp_t parameter_change_ramp_in,
  // move request; arcs arrive as successive chord segments
  input wire logic move_valid_in,
  input wire mpi_pkg::mpi_move_t move_in,
  output logic move_ready_out,
  // servo speed references and status
  output logic [AXES*mpi_pkg::VW-1:0] speed_ref_out,
  output logic move_done_out,
  output logic supplemental_axis_overspeed_error_out
);
  localparam int VW = mpi_pkg::VW;
  localparam int DW = mpi_pkg::DW;
  localparam int TW = mpi_pkg::TW;
  initial begin
    if (AXES != mpi_pkg::AXES || CTRL_CYC < 1) $error("mpi_top: unsupported parameters");
  end
  // a / b * c, saturating to the output width
  function automatic logic [VW-1:0] scale(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                          input logic [VW-1:0] c);
    logic [DW+VW-1:0] p;
    p = (b == '0) ? '0 : (a * c) / b;
    scale = (p > (DW+VW)'({VW{1'b1}})) ? {VW{1'b1}} : VW'(p);
  endfunction : scale
  // t * f / m, at least one period
  function automatic logic [TW-1:0] tscale(input logic [TW-1:0] t, input logic [VW-1:0] f,
                                           input logic [VW-1:0] m);
    logic [TW+VW-1:0] p;
    p = (m == '0) ? (TW+VW)'(t) : (t * f) / m;
    tscale = (p == '0) ? mpi_pkg::TIME_ONE : TW'(p);
  endfunction : tscale
  // control period timer
  logic [mpi_pkg::CNT_W-1:0] tick_cnt_reg;
  logic tick_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == mpi_pkg::CNT_W'(CTRL_CYC - 1));
      tick_cnt_reg <= (tick_cnt_reg == mpi_pkg::CNT_W'(CTRL_CYC - 1)) ? '0
                      : tick_cnt_reg + mpi_pkg::CNT_W'(1);
    end
  end
  // interpolation ramp times: system parameters until a program command overrides
  mpi_pkg::mpi_ramp_t iramp_reg;
  logic iramp_cmd_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      iramp_cmd_reg <= 1'b0;
      iramp_reg <= '0;
    end else if (parameter_change_command_in) begin
      iramp_cmd_reg <= 1'b1;
      iramp_reg <= parameter_change_ramp_in;
    end
  end
  wire mpi_pkg::mpi_ramp_t iramp = iramp_cmd_reg ? iramp_reg : interp_ramp_in;
  // move decoding
  wire logic is_ptp = (move_in.kind == mpi_pkg::MPI_PTP);
  wire logic is_helix = (move_in.kind == mpi_pkg::MPI_HELIX);
  wire logic [2:0] n_axes = 3'(move_in.axis_sel[0]) + 3'(move_in.axis_sel[1])
                            + 3'(move_in.axis_sel[2]) + 3'(move_in.axis_sel[3]);
  wire logic single = (n_axes == 3'h1);
  // option is a plain input held low by the system default; only one-axis moves see it
  wire logic ca_use = const_accel_en_in && single && !is_helix;
  wire logic [TW-1:0] i_acc = ca_use ? tscale(iramp.accel, move_in.feed, interp_max_feed_in)
                              : iramp.accel;
  wire logic [TW-1:0] i_dec = ca_use ? tscale(iramp.decel, move_in.feed, interp_max_feed_in)
                              : iramp.decel;
  // path travel time at commanded rate, in control periods
  wire logic [TW-1:0] i_travel = TW'(scale(move_in.path_len, DW'(move_in.feed), VW'(1)));
  wire logic [TW:0] i_sum = (TW+1)'(i_acc) + (TW+1)'(i_dec);
  // half ramp sum in distance terms: trapezoid needs travel >= (acc+dec)/2
  wire logic i_short = ((TW+1)'(i_travel) << 1) < i_sum;
  // stop mode: triangle, times shrink keeping the ratio, peak follows
  wire logic [TW-1:0] tri_acc = tscale(i_acc, VW'(i_travel << 1), VW'(i_sum));
  wire logic [TW-1:0] tri_dec = tscale(i_dec, VW'(i_travel << 1), VW'(i_sum));
  wire logic [VW-1:0] tri_pk = scale(DW'(tri_acc) + DW'(tri_dec), DW'(i_sum), move_in.feed);
  // pass mode: full times kept, peak lowered to fit the distance
  wire logic [VW-1:0] pass_pk = scale(DW'(i_travel << 1), DW'(i_sum), move_in.feed);
  wire logic [VW-1:0] path_pk = !i_short ? move_in.feed
                                : (pass_mode_in ? pass_pk : tri_pk);
  wire logic [TW-1:0] p_acc = (i_short && !pass_mode_in) ? tri_acc : i_acc;
  wire logic [TW-1:0] p_dec = (i_short && !pass_mode_in) ? tri_dec : i_dec;
  wire logic [TW-1:0] p_run = i_short ? '0 : TW'(i_travel - TW'(i_sum >> 1));
  // helix supplemental axis rate (axis 2) timed from the arc rate; compared as cross products
  // so that a rate just above the limit is not lost to the rounding of a division
  wire logic [DW+VW-1:0] sup_num = (DW+VW)'(move_in.sup_len) * (DW+VW)'(move_in.feed);
  wire logic [DW+VW-1:0] sup_lim = (DW+VW)'(move_in.path_len) * (DW+VW)'(interp_max_feed_in);
  wire logic sup_over = is_helix && (sup_num > sup_lim);
  // move acceptance
  logic [AXES-1:0] busy;
  logic [AXES-1:0] done;
  logic err_reg, ready_reg, done_reg, active_reg;
  wire logic take = move_valid_in && ready_reg && !err_reg;
  wire logic all_idle = (busy == '0);
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      err_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      if (take && sup_over) err_reg <= 1'b1;
      ready_reg <= all_idle && !active_reg && !take && !err_reg;
      active_reg <= take && !sup_over;
      done_reg <= (done != '0) && (busy == '0);
    end
  end
  wire logic go = take && !sup_over;
  // per-axis ramp settings
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      wire logic [VW-1:0] amax = axis_max_feed_in[g*VW +: VW];
      wire logic [DW-1:0] adist = move_in.axis_dist[g*DW +: DW];
      // ptp: rate fixed by ramp time over full range; override scales peak and time together
      wire logic [VW-1:0] o_pk = scale(DW'(override_pct_in), DW'(100), amax);
      wire logic [TW-1:0] o_acc = tscale(ptp_ramp_in.accel, o_pk, amax);
      wire logic [TW-1:0] o_dec = tscale(ptp_ramp_in.decel, o_pk, amax);
      wire logic [TW-1:0] a_trav = TW'(scale(adist, DW'(o_pk), VW'(1)));
      wire logic [TW:0] a_sum = (TW+1)'(o_acc) + (TW+1)'(o_dec);
      wire logic a_short = ((TW+1)'(a_trav) << 1) < a_sum;
      wire logic [TW-1:0] t_acc = tscale(o_acc, VW'(a_trav << 1), VW'(a_sum));
      wire logic [TW-1:0] t_dec = tscale(o_dec, VW'(a_trav << 1), VW'(a_sum));
      wire logic [VW-1:0] t_pk = scale(DW'(t_acc) + DW'(t_dec), DW'(a_sum), o_pk);
      // interpolated: axis share of path speed; the helix axis uses its own length
      wire logic [DW-1:0] l_dist = (g == 2 && is_helix) ? move_in.sup_len : adist;
      wire logic [VW-1:0] l_pk = scale(l_dist, move_in.path_len, path_pk);
      wire logic [VW-1:0] pk = is_ptp ? (a_short ? t_pk : o_pk) : l_pk;
      wire logic [TW-1:0] ta = is_ptp ? (a_short ? t_acc : o_acc) : p_acc;
      wire logic [TW-1:0] td = is_ptp ? (a_short ? t_dec : o_dec) : p_dec;
      wire logic [TW-1:0] tr = is_ptp ? (a_short ? '0 : TW'(a_trav - TW'(a_sum >> 1))) : p_run;
      wire logic [VW-1:0] spd;
      mpi_ramp #(.VW(VW), .TW(TW)) u_ramp (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .tick_in(tick_reg && !err_reg),
        .start_in(go && move_in.axis_sel[g]),
        .peak_in(pk),
        .acc_t_in(ta),
        .dec_t_in(td),
        .cruise_t_in(tr),
        .speed_out(spd),
        .busy_out(busy[g]),
        .done_out(done[g])
      );
      logic [VW-1:0] ref_reg;
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) ref_reg <= mpi_pkg::SPEED_ZERO;
        else ref_reg <= err_reg ? mpi_pkg::SPEED_ZERO : spd;
      end
      assign speed_ref_out[g*VW +: VW] = ref_reg;
    end
  endgenerate
  assign move_ready_out = ready_reg;
  assign move_done_out = done_reg;
  assign supplemental_axis_overspeed_error_out = err_reg;
endmodule : mpi_top
